// >>> rlsel_pkg.sv
// Package: constants and types for the relay output source selector
package rlsel_pkg;

  // ----------------------------------------------------------------
  // Source select codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SRC_RUN          = 5'h00;
  localparam logic [4:0] SRC_FREQ_REACHED = 5'h01;
  localparam logic [4:0] SRC_FREQ_EXCEED  = 5'h02;
  localparam logic [4:0] SRC_OVERLOAD     = 5'h03;
  localparam logic [4:0] SRC_PID_DEV      = 5'h04;
  localparam logic [4:0] SRC_FAULT        = 5'h05;
  localparam logic [4:0] SRC_FREQ_RANGE   = 5'h06;
  localparam logic [4:0] SRC_TORQUE_OVER  = 5'h07;
  localparam logic [4:0] SRC_MAINS_STOP   = 5'h08;
  localparam logic [4:0] SRC_UNDERVOLT    = 5'h09;
  localparam logic [4:0] SRC_TORQUE_LIM   = 5'h0a;
  localparam logic [4:0] SRC_RUN_TIME     = 5'h0b;
  localparam logic [4:0] SRC_POWER_TIME   = 5'h0c;
  localparam logic [4:0] SRC_MOTOR_THERM  = 5'h0d;
  localparam logic [4:0] SRC_RSVD_FIRST   = 5'h0e;
  localparam logic [4:0] SRC_RSVD_LAST    = 5'h12;
  localparam logic [4:0] SRC_BRAKE_EN     = 5'h13;
  localparam logic [4:0] SRC_BRAKE_ERR    = 5'h14;
  localparam logic [4:0] SRC_ZERO_SPEED   = 5'h15;
  localparam logic [4:0] SRC_SPEED_DEV    = 5'h16;
  localparam logic [4:0] SRC_POS_DONE     = 5'h17;
  localparam logic [4:0] SRC_FREQ_EXC_ALT = 5'h18;
  localparam logic [4:0] SRC_FREQ_REA_ALT = 5'h19;
  localparam logic [4:0] SRC_OVERLOAD_ALT = 5'h1a;
  localparam logic [4:0] SRC_DEFAULT      = SRC_FAULT;
  localparam int         SRC_COUNT        = 27;

  // ----------------------------------------------------------------
  // Contact polarity
  // ----------------------------------------------------------------
  localparam logic       POL_MAKE         = 1'h0;
  localparam logic       POL_BREAK        = 1'h1;
  localparam logic       POL_DEFAULT      = POL_BREAK;

  // ----------------------------------------------------------------
  // Parameter set identifier digits
  // ----------------------------------------------------------------
  localparam logic [3:0] PSET_DIGIT_FIRST  = 4'h0;
  localparam logic [3:0] PSET_DIGIT_SECOND = 4'h2;
  localparam logic [3:0] PSET_DIGIT_THIRD  = 4'h3;

  typedef enum logic [1:0] {
    PSET_FIRST  = 2'b00,
    PSET_SECOND = 2'b01,
    PSET_THIRD  = 2'b10
  } rlsel_pset_t;

  // ----------------------------------------------------------------
  // Power-up hold of the relay
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int STARTUP_HOLD_NS = 100000;
  localparam int STARTUP_CYCLES = (STARTUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    ST_POWERUP = 1'b0,
    ST_ACTIVE  = 1'b1
  } rlsel_state_t;

  // ----------------------------------------------------------------
  // Fault history
  // ----------------------------------------------------------------
  localparam int HIST_DEPTH = 6;
  localparam int REC_WIDTH  = 16;

  // Reserved codes give an inactive condition
  function automatic logic cond_select(input logic [4:0] code, input logic [SRC_COUNT-1:0] flags);
    logic res;
    res = 1'b0;
    if ((code >= SRC_RSVD_FIRST && code <= SRC_RSVD_LAST) || code > SRC_OVERLOAD_ALT)
      res = 1'b0;
    else
      res = flags[code];
    return res;
  endfunction : cond_select

endpackage : rlsel_pkg

// >>> rlsel_hist_if.sv
// Interface: fault history write and read between selector and store
interface rlsel_hist_if #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 16
);
  logic                     wr_en;
  logic [WIDTH-1:0]         wr_data;
  logic [$clog2(DEPTH)-1:0] rd_idx;
  logic [WIDTH-1:0]         rd_data;

  modport ctrl (output wr_en, output wr_data, output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_data, input rd_idx, output rd_data);
endinterface : rlsel_hist_if

// >>> rlsel_hist_mem.sv
// Fault history store: newest record at index 0, contents kept through reset
module rlsel_hist_mem #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // History port
  rlsel_hist_if.mem hist
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_ff;

  // ----------------------------------------------------------------
  // Storage, deliberately without reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (hist.wr_en)
    begin
      mem_ff[0] <= hist.wr_data;
      for (int i = 1; i < DEPTH; i++)
      begin
        mem_ff[i] <= mem_ff[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      rd_ff <= '0;
    else if (32'(hist.rd_idx) < DEPTH)
      rd_ff <= mem_ff[hist.rd_idx];
    else
      rd_ff <= '0;
  end

  assign hist.rd_data = rd_ff;

endmodule : rlsel_hist_mem

// >>> rlsel_top.sv
// Top: relay source selection, contact polarity, power-up hold, fault history

// Notes on behaviour
// - Codes 00-05: run, reached, exceeded, overload, PID, fault
// - Codes 06-13: range, torque, mains, UV, limits, thermal
// - Codes 19,20,24-26: brake enable, brake fault, alternates
// - Codes 21-23: zero speed, deviation, position done
// - Polarity 00 make on condition; 01 break
// - Latest fault record survives supply loss
// - Power-up clears relay state, no old fault
// - Break polarity: fault position briefly after power-up
// - Identifier digit 0,2,3 selects parameter set
// - Break polarity: common-break open normal, reversed fault
module rlsel_top #(
  parameter int STARTUP_CYCLES = rlsel_pkg::STARTUP_CYCLES,
  parameter int HIST_DEPTH     = rlsel_pkg::HIST_DEPTH,
  parameter int REC_WIDTH      = rlsel_pkg::REC_WIDTH
) (
  // Clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_n,
  // Configuration
  input  wire logic [4:0]                    i_relay_source_select,
  input  wire logic                          i_relay_contact_polarity,
  input  wire logic [3:0]                    i_param_id_digit,
  // Status conditions
  input  wire logic                          i_run_flag,
  input  wire logic                          i_freq_reached_flag,
  input  wire logic                          i_freq_exceeded_flag,
  input  wire logic                          i_overload_alarm_flag,
  input  wire logic                          i_pid_deviation_flag,
  input  wire logic                          i_fault_alarm_signal,
  input  wire logic                          i_freq_in_range_flag,
  input  wire logic                          i_torque_exceeded_flag,
  input  wire logic                          i_mains_loss_stop_flag,
  input  wire logic                          i_undervoltage_flag,
  input  wire logic                          i_torque_limit_flag,
  input  wire logic                          i_run_time_over_flag,
  input  wire logic                          i_power_time_over_flag,
  input  wire logic                          i_motor_thermal_flag,
  input  wire logic                          i_brake_release_enable,
  input  wire logic                          i_brake_error_flag,
  input  wire logic                          i_zero_speed_flag,
  input  wire logic                          i_speed_deviation_flag,
  input  wire logic                          i_position_done_flag,
  input  wire logic                          i_freq_exceeded_alt_flag,
  input  wire logic                          i_freq_reached_alt_flag,
  input  wire logic                          i_overload_alarm_alt_flag,
  // Fault history
  input  wire logic                          i_fault_rec_wr,
  input  wire logic [REC_WIDTH-1:0]          i_fault_rec_data,
  input  wire logic [$clog2(HIST_DEPTH)-1:0] i_hist_rd_idx,
  output logic      [REC_WIDTH-1:0]          o_hist_rd_data,
  // Relay and status
  output logic                               o_relay_coil,
  output logic                               o_relay_make_closed,
  output logic                               o_relay_break_closed,
  output logic                               o_startup_done,
  output logic      [1:0]                    o_param_set,
  output logic                               o_param_id_valid
);

  localparam int CW = $clog2(STARTUP_CYCLES + 1);

  logic [rlsel_pkg::SRC_COUNT-1:0] flags;
  logic                            cond_ff;
  logic                            nxt_cond;
  logic                            coil_ff;
  logic                            nxt_coil;
  logic [CW-1:0]                   cnt_ff;
  rlsel_pkg::rlsel_state_t         state_ff;
  rlsel_pkg::rlsel_pset_t          pset_ff;
  logic                            pid_valid_ff;

  rlsel_hist_if #(.DEPTH(HIST_DEPTH), .WIDTH(REC_WIDTH)) hist ();

  // ----------------------------------------------------------------
  // Condition vector indexed by source code
  // ----------------------------------------------------------------
  always_comb
  begin
    flags                                       = '0;
    flags[rlsel_pkg::SRC_RUN]                   = i_run_flag;
    flags[rlsel_pkg::SRC_FREQ_REACHED]          = i_freq_reached_flag;
    flags[rlsel_pkg::SRC_FREQ_EXCEED]           = i_freq_exceeded_flag;
    flags[rlsel_pkg::SRC_OVERLOAD]              = i_overload_alarm_flag;
    flags[rlsel_pkg::SRC_PID_DEV]               = i_pid_deviation_flag;
    flags[rlsel_pkg::SRC_FAULT]                 = i_fault_alarm_signal;
    flags[rlsel_pkg::SRC_FREQ_RANGE]            = i_freq_in_range_flag;
    flags[rlsel_pkg::SRC_TORQUE_OVER]           = i_torque_exceeded_flag;
    flags[rlsel_pkg::SRC_MAINS_STOP]            = i_mains_loss_stop_flag;
    flags[rlsel_pkg::SRC_UNDERVOLT]             = i_undervoltage_flag;
    flags[rlsel_pkg::SRC_TORQUE_LIM]            = i_torque_limit_flag;
    flags[rlsel_pkg::SRC_RUN_TIME]              = i_run_time_over_flag;
    flags[rlsel_pkg::SRC_POWER_TIME]            = i_power_time_over_flag;
    flags[rlsel_pkg::SRC_MOTOR_THERM]           = i_motor_thermal_flag;
    flags[rlsel_pkg::SRC_BRAKE_EN]              = i_brake_release_enable;
    flags[rlsel_pkg::SRC_BRAKE_ERR]             = i_brake_error_flag;
    flags[rlsel_pkg::SRC_ZERO_SPEED]            = i_zero_speed_flag;
    flags[rlsel_pkg::SRC_SPEED_DEV]             = i_speed_deviation_flag;
    flags[rlsel_pkg::SRC_POS_DONE]              = i_position_done_flag;
    flags[rlsel_pkg::SRC_FREQ_EXC_ALT]          = i_freq_exceeded_alt_flag;
    flags[rlsel_pkg::SRC_FREQ_REA_ALT]          = i_freq_reached_alt_flag;
    flags[rlsel_pkg::SRC_OVERLOAD_ALT]          = i_overload_alarm_alt_flag;
  end

  assign nxt_cond = rlsel_pkg::cond_select(i_relay_source_select, flags);

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      cond_ff <= 1'b0;
    else
      cond_ff <= nxt_cond;
  end

  // ----------------------------------------------------------------
  // Power-up hold: coil stays released until the hold expires
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      state_ff <= rlsel_pkg::ST_POWERUP;
      cnt_ff   <= '0;
    end
    else
    begin
      case (state_ff)
        rlsel_pkg::ST_POWERUP:
        begin
          if (cnt_ff == CW'(STARTUP_CYCLES - 1))
            state_ff <= rlsel_pkg::ST_ACTIVE;
          else
            cnt_ff <= cnt_ff + CW'(1);
        end
        rlsel_pkg::ST_ACTIVE:
          state_ff <= rlsel_pkg::ST_ACTIVE;
        default:
          state_ff <= rlsel_pkg::ST_POWERUP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Coil drive with contact polarity
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_coil = 1'b0;
    if (state_ff == rlsel_pkg::ST_ACTIVE)
    begin
      if (i_relay_contact_polarity == rlsel_pkg::POL_MAKE)
        nxt_coil = cond_ff;
      else
        nxt_coil = ~cond_ff;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      coil_ff <= 1'b0;
    else
      coil_ff <= nxt_coil;
  end

  assign o_relay_coil         = coil_ff;
  assign o_relay_make_closed  = coil_ff;
  assign o_relay_break_closed = ~coil_ff;
  assign o_startup_done       = (state_ff == rlsel_pkg::ST_ACTIVE);

  // ----------------------------------------------------------------
  // Parameter set decode
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      pset_ff      <= rlsel_pkg::PSET_FIRST;
      pid_valid_ff <= 1'b0;
    end
    else
    begin
      pid_valid_ff <= 1'b1;
      case (i_param_id_digit)
        rlsel_pkg::PSET_DIGIT_FIRST:  pset_ff <= rlsel_pkg::PSET_FIRST;
        rlsel_pkg::PSET_DIGIT_SECOND: pset_ff <= rlsel_pkg::PSET_SECOND;
        rlsel_pkg::PSET_DIGIT_THIRD:  pset_ff <= rlsel_pkg::PSET_THIRD;
        default:
        begin
          pset_ff      <= rlsel_pkg::PSET_FIRST;
          pid_valid_ff <= 1'b0;
        end
      endcase
    end
  end

  assign o_param_set      = pset_ff;
  assign o_param_id_valid = pid_valid_ff;

  // ----------------------------------------------------------------
  // Fault history store
  // ----------------------------------------------------------------
  assign hist.wr_en   = i_fault_rec_wr;
  assign hist.wr_data = i_fault_rec_data;
  assign hist.rd_idx  = i_hist_rd_idx;
  assign o_hist_rd_data = hist.rd_data;

  rlsel_hist_mem #(
    .DEPTH (HIST_DEPTH),
    .WIDTH (REC_WIDTH)
  ) u_hist (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .hist    (hist)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_run_code_map: assert property (
    (i_relay_source_select == rlsel_pkg::SRC_RUN) |=> (cond_ff == $past(i_run_flag)))
    else $error("run code not mapped to run flag");
  a_fault_code_map: assert property (
    (i_relay_source_select == rlsel_pkg::SRC_FAULT) |=> (cond_ff == $past(i_fault_alarm_signal)))
    else $error("fault code not mapped to fault signal");
  a_thermal_code_map: assert property (
    (i_relay_source_select == rlsel_pkg::SRC_MOTOR_THERM) |=> (cond_ff == $past(i_motor_thermal_flag)))
    else $error("thermal code mismatch");
  a_brake_code_map: assert property (
    (i_relay_source_select == rlsel_pkg::SRC_BRAKE_EN) |=> (cond_ff == $past(i_brake_release_enable)))
    else $error("brake enable code mismatch");
  a_encoder_code_map: assert property (
    (i_relay_source_select == rlsel_pkg::SRC_POS_DONE) |=> (cond_ff == $past(i_position_done_flag)))
    else $error("positioning code mismatch");
  a_reserved_idle: assert property (
    ((i_relay_source_select inside {[rlsel_pkg::SRC_RSVD_FIRST:rlsel_pkg::SRC_RSVD_LAST]})
     || (i_relay_source_select > rlsel_pkg::SRC_OVERLOAD_ALT)) |=> !cond_ff)
    else $error("reserved code gave active condition");
  a_polarity_path: assert property (
    (state_ff == rlsel_pkg::ST_ACTIVE && $stable(i_relay_contact_polarity))
    |=> (coil_ff == ($past(cond_ff) ^ $past(i_relay_contact_polarity))))
    else $error("coil does not follow condition and polarity");
  a_powerup_release: assert property (
    (state_ff == rlsel_pkg::ST_POWERUP) |=> !coil_ff)
    else $error("coil energised during power-up hold");
  a_reset_clear: assert property (
    disable iff (1'b0) !i_rst_n |=> (!coil_ff && state_ff == rlsel_pkg::ST_POWERUP))
    else $error("reset did not clear relay state");
  a_contacts_pair: assert property (
    o_relay_make_closed != o_relay_break_closed)
    else $error("both contacts in same state");
  a_break_contacts: assert property (
    (state_ff == rlsel_pkg::ST_ACTIVE && i_relay_contact_polarity == rlsel_pkg::POL_BREAK)
    |=> (o_relay_break_closed == $past(cond_ff) && o_relay_make_closed == !$past(cond_ff)))
    else $error("break polarity contacts wrong for condition");
  a_hist_latest: assert property (
    (i_fault_rec_wr ##1 (i_hist_rd_idx == '0 && !i_fault_rec_wr))
    |=> (o_hist_rd_data == $past(i_fault_rec_data, 2)))
    else $error("latest fault record not read back");
  a_pset_second: assert property (
    (i_param_id_digit == rlsel_pkg::PSET_DIGIT_SECOND) |=> (o_param_set == rlsel_pkg::PSET_SECOND && o_param_id_valid))
    else $error("second parameter set not selected");

  c_startup_end: cover property ($rose(o_startup_done));
  c_fault_break: cover property (o_startup_done && i_relay_contact_polarity && cond_ff ##1 !coil_ff);
  c_make_close: cover property (o_startup_done && !i_relay_contact_polarity && cond_ff ##1 coil_ff);
  c_hist_write: cover property (i_fault_rec_wr ##1 i_fault_rec_wr);

endmodule : rlsel_top

// >>> rlsel_relay_load.sv
// Contact monitor: external equipment reading the changeover relay
module rlsel_relay_load (
  // Clock
  input  wire logic i_mclk,
  // Relay contacts
  input  wire logic i_make_closed,
  input  wire logic i_break_closed,
  // Sensed contact state
  output logic      o_make_sensed,
  output logic      o_break_sensed,
  output logic      o_contact_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Contact reading
  // ----------------------------------------------------------------
  assign o_make_sensed  = i_make_closed;
  assign o_break_sensed = i_break_closed;

  // Sticky: both pairs closed or both open is never legal
  initial o_contact_fault = 1'h0;
  always @(posedge i_mclk)
  begin
    if ((i_make_closed ^ i_break_closed) === 1'h0)
      o_contact_fault <= 1'h1;
  end
endmodule : rlsel_relay_load

// >>> rlsel_top_tb.sv
// Testbench: relay source selection, polarity, power-up hold, history
module rlsel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 8;

  typedef struct packed {
    logic [1:0]  grp;
    logic [15:0] val;
  } rlsel_exp_t;

  logic        i_mclk   = 1'h0;
  logic        i_rst_n  = 1'h0;
  logic [4:0]  src      = 5'h05;
  logic        pol      = 1'h1;
  logic [3:0]  digit    = 4'h0;
  logic [26:0] flags    = 27'h0;
  logic        rec_wr   = 1'h0;
  logic [15:0] rec_data = 16'h0;
  logic [2:0]  rd_idx   = 3'h0;
  logic [15:0] hist_data;
  logic        coil;
  logic        make_c;
  logic        brk_c;
  logic        make_s;
  logic        brk_s;
  logic        c_fault;
  logic        st_done;
  logic [1:0]  pset;
  logic        pvalid;
  logic        cnd;
  logic [15:0] recs [7];
  rlsel_exp_t  expq [$];
  int          mismatches = 0;
  int          compares   = 0;
  event        chk_ev;

  always #2 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------
  // Design and contact monitor
  // ----------------------------------------------------------------
  rlsel_top #(.STARTUP_CYCLES(HOLD)) u_rlsel_top (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_relay_source_select(src),
    .i_relay_contact_polarity(pol), .i_param_id_digit(digit),
    .i_run_flag(flags[0]), .i_freq_reached_flag(flags[1]), .i_freq_exceeded_flag(flags[2]),
    .i_overload_alarm_flag(flags[3]), .i_pid_deviation_flag(flags[4]), .i_fault_alarm_signal(flags[5]),
    .i_freq_in_range_flag(flags[6]), .i_torque_exceeded_flag(flags[7]), .i_mains_loss_stop_flag(flags[8]),
    .i_undervoltage_flag(flags[9]), .i_torque_limit_flag(flags[10]), .i_run_time_over_flag(flags[11]),
    .i_power_time_over_flag(flags[12]), .i_motor_thermal_flag(flags[13]),
    .i_brake_release_enable(flags[19]), .i_brake_error_flag(flags[20]), .i_zero_speed_flag(flags[21]),
    .i_speed_deviation_flag(flags[22]), .i_position_done_flag(flags[23]),
    .i_freq_exceeded_alt_flag(flags[24]), .i_freq_reached_alt_flag(flags[25]),
    .i_overload_alarm_alt_flag(flags[26]), .i_fault_rec_wr(rec_wr), .i_fault_rec_data(rec_data),
    .i_hist_rd_idx(rd_idx), .o_hist_rd_data(hist_data), .o_relay_coil(coil),
    .o_relay_make_closed(make_c), .o_relay_break_closed(brk_c), .o_startup_done(st_done),
    .o_param_set(pset), .o_param_id_valid(pvalid)
  );

  rlsel_relay_load u_rlsel_relay_load (
    .i_mclk(i_mclk), .i_make_closed(make_c), .i_break_closed(brk_c),
    .o_make_sensed(make_s), .o_break_sensed(brk_s), .o_contact_fault(c_fault)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] relay_exp(input logic done, input logic rc);
    return {11'h0, 1'h0, done, rc, rc, ~rc};
  endfunction : relay_exp

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Let the latency pass, note the expectation, then have it compared
  task automatic expect_out(input logic [1:0] grp, input logic [15:0] val, input int waits);
    repeat (waits) @(negedge i_mclk);
    expq.push_back('{grp: grp, val: val});
    ->chk_ev;
  endtask : expect_out

  task automatic summarize();
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  // Drains every due note: triggers in one time step can merge
  always @(chk_ev)
  begin
    rlsel_exp_t e;
    while (expq.size() > 0)
    begin
      e = expq.pop_front();
      case (e.grp)
        2'h0:    check({11'h0, c_fault, st_done, coil, make_s, brk_s}, e.val);
        2'h1:    check({13'h0, pvalid, pset}, e.val);
        default: check(hist_data, e.val);
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    #100000;
    mismatches++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hf837));
    repeat (8) @(negedge i_mclk);
    expect_out(2'h0, relay_exp(1'h0, 1'h0), 0);
    expect_out(2'h1, 16'h0, 0);
    expect_out(2'h2, 16'h0, 0);
    // Break polarity, no fault: fault position until the hold ends
    i_rst_n = 1'h1;
    expect_out(2'h0, relay_exp(1'h0, 1'h0), 4);
    expect_out(2'h0, relay_exp(1'h1, 1'h1), HOLD);
    // Every code in both polarities, flags random then inverted
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 32; c++)
        for (int k = 0; k < 2; k++)
        begin
          @(negedge i_mclk);
          pol   = p[0];
          src   = c[4:0];
          flags = (k == 0) ? 27'($urandom()) : ~flags;
          cnd   = ((c >= 14 && c <= 18) || c > 26) ? 1'h0 : flags[c];
          expect_out(2'h0, relay_exp(1'h1, cnd ^ pol), 3);
        end
    // Parameter set digits
    for (int d = 0; d < 16; d++)
    begin
      @(negedge i_mclk);
      digit = d[3:0];
      expect_out(2'h1, (d == 0) ? 16'h4 : (d == 2) ? 16'h5 : (d == 3) ? 16'h6 : 16'h0, 2);
    end
    // Back-to-back fault records, one more than the depth
    for (int i = 0; i < 7; i++)
    begin
      @(negedge i_mclk);
      rec_wr   = 1'h1;
      rec_data = 16'($urandom());
      recs[i]  = rec_data;
    end
    @(negedge i_mclk);
    rec_wr = 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      rd_idx = i[2:0];
      expect_out(2'h2, (i < 6) ? recs[6 - i] : 16'h0, 2);
    end
    // Fault present across a second power-up, make polarity
    pol   = 1'h0;
    src   = 5'h05;
    flags = 27'h7ffffff;
    i_rst_n = 1'h0;
    rd_idx  = 3'h0;
    repeat (8) @(negedge i_mclk);
    i_rst_n = 1'h1;
    expect_out(2'h0, relay_exp(1'h0, 1'h0), 4);
    expect_out(2'h2, recs[6], 0);
    expect_out(2'h0, relay_exp(1'h1, 1'h1), HOLD);
    repeat (2) @(negedge i_mclk);
    summarize();
  end
endmodule : rlsel_top_tb
